// >>> hw/arf_pkg.sv
// shared constants and types of the converter result formatter and clock block
package arf_pkg;

	localparam int ARF_DATA_W = 32;
	localparam int ARF_RES_W = 10;
	localparam int ARF_BYTE_W = 8;
	localparam int ARF_ADDR_W = 10;

	// register indices; byte address is index shifted left by two
	localparam logic [7:0] ARF_IDX_RESULT_HIGH = 8'h3D;
	localparam logic [7:0] ARF_IDX_RESULT_LOW = 8'h3E;
	localparam logic [7:0] ARF_IDX_CLOCK_CONTROL = 8'h3F;
	localparam int ARF_IDX_SHIFT = 2;

	// conversion_clock_control field layout
	localparam int ARF_PRE_LSB = 5;
	localparam int ARF_PRE_W = 3;
	localparam int ARF_ICS_BIT = 4;
	localparam int ARF_MODE_LSB = 2;
	localparam int ARF_MODE_W = 2;

	localparam logic [2:0] ARF_PRE_RESET = 3'h0;
	localparam logic ARF_ICS_OSC = 1'b0;
	localparam logic ARF_ICS_BUS = 1'b1;
	localparam logic [7:0] ARF_RESULT_RESET = 8'h00;
	localparam logic [31:0] ARF_RDATA_ZERO = 32'h0000_0000;

	// prescaler: code with top bit set divides by 2^4
	localparam int ARF_DIV_CNT_W = 4;
	localparam logic [2:0] ARF_DIV_LOG_MAX = 3'h4;

	typedef enum logic [1:0]
	{
		ARF_MODE_TRUNC = 2'h0,
		ARF_MODE_RIGHT = 2'h1,
		ARF_MODE_LEFT = 2'h2,
		ARF_MODE_LEFT_SIGNED = 2'h3
	} arf_mode_e;

	localparam arf_mode_e ARF_MODE_RESET = ARF_MODE_RIGHT;

	// read-order interlock state, one-hot
	typedef enum logic [1:0]
	{
		ARF_LOCK_OPEN = 2'b01,
		ARF_LOCK_HELD = 2'b10
	} arf_lock_e;

	typedef struct packed
	{
		logic [ARF_DIV_CNT_W-1:0] cnt;
		logic tick;
	} arf_div_s;

	typedef struct packed
	{
		logic [7:0] high;
		logic [7:0] low;
		logic [ARF_PRE_W-1:0] prescale;
		logic clk_sel;
		arf_mode_e mode;
		arf_lock_e lock;
		logic osc_q;
		logic restart;
		logic [ARF_DATA_W-1:0] prdata;
		logic pready;
		logic pslverr;
	} arf_top_s;

endpackage

// >>> hw/arf_prescaler.sv
// power-of-two prescaler producing the conversion clock enable
`timescale 1ns/1ns
module arf_prescaler
#(
	parameter int CNT_W = 4
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic src_tick,
	input wire logic restart,
	input wire logic [2:0] div_code,
	output logic conv_tick
);
	import arf_pkg::*;

	initial
	begin
		if (CNT_W != ARF_DIV_CNT_W)
			$error("prescaler counter width must match the divide by sixteen state");
	end

	arf_div_s st;
	arf_div_s next_st;
	logic [2:0] div_log;
	logic [CNT_W-1:0] limit;

	always_comb
	begin
		// top code bit forces the largest ratio
		div_log = div_code[2] ? ARF_DIV_LOG_MAX : {1'b0, div_code[1:0]};
		limit = CNT_W'(({{(CNT_W){1'b0}}, 1'b1} << div_log) - 1'b1);
		next_st = st;
		next_st.tick = 1'b0;
		if (restart)
		begin
			next_st.cnt = '0;
		end
		else if (src_tick)
		begin
			if (st.cnt >= limit)
			begin
				next_st.cnt = '0;
				next_st.tick = 1'b1;
			end
			else
			begin
				next_st.cnt = CNT_W'(st.cnt + 1'b1);
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st <= '0;
		end
		else
		begin
			st <= next_st;
		end
	end

	assign conv_tick = st.tick;

endmodule

// >>> hw/arf_top.sv
// converter result formatter, read interlock and conversion clock control
//
// Functional notes
// - left-justified signed mode puts result bits 9..2 in the high byte with bit 9 inverted and bits 1..0 in low byte bits 7..6.
// - left-justified signed mode refreshes both result bytes on a finished conversion only while the read interlock is open.
// - outside truncated mode, reading the high byte freezes the low byte until the low byte is read.
// - after a high byte read outside truncated mode every new result is dropped until software reads the low byte.
// - the prescale field divides the input clock by 1, 2, 4, 8, or 16 for any code with its top bit set.
// - input clock select set picks the bus clock, cleared picks the oscillator clock, which reset selects.
// - the justification field picks truncated, right, left or left signed layout, reset giving right-justified.
// - truncated mode puts the top eight bits in the low byte, high byte zero, updated always without interlock.
// - right-justified mode puts bits 9..8 in high byte bits 1..0 and bits 7..0 in the low byte, interlocked.
// - left-justified mode puts bits 9..2 in the high byte and bits 1..0 in low byte bits 7..6, interlocked.
`timescale 1ns/1ns
module arf_top
#(
	parameter int ADDR_W = arf_pkg::ARF_ADDR_W,
	parameter int RES_W = arf_pkg::ARF_RES_W
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [arf_pkg::ARF_DATA_W-1:0] pwdata,
	output logic [arf_pkg::ARF_DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic oscillator_clock,
	input wire logic conv_done,
	input wire logic [RES_W-1:0] conv_result,
	output logic conv_clk_en,
	output logic [arf_pkg::ARF_BYTE_W-1:0] result_high_byte,
	output logic [arf_pkg::ARF_BYTE_W-1:0] result_low_byte
);
	import arf_pkg::*;

	initial
	begin
		if (ADDR_W < ARF_ADDR_W)
			$error("address bus too narrow for the register indices");
		if (RES_W != ARF_RES_W)
			$error("result formatting serves ten-bit results only");
		if (ARF_PRE_LSB + ARF_PRE_W > ARF_BYTE_W)
			$error("prescale field outside the control byte");
		if (ARF_MODE_LSB + ARF_MODE_W > ARF_ICS_BIT)
			$error("justification field overlaps the clock select bit");
	end

	arf_top_s st;
	arf_top_s next_st;

	logic setup;
	logic access;
	logic wr_acc;
	logic rd_acc;
	logic [ADDR_W-ARF_IDX_SHIFT-1:0] word_idx;
	logic aligned;
	logic hit_high;
	logic hit_low;
	logic hit_ctrl;
	logic hit_any;
	logic [7:0] ctrl_rd;
	logic [7:0] wr_byte;
	logic [ARF_PRE_W-1:0] wr_pre;
	logic wr_sel;
	arf_mode_e wr_mode;
	logic high_read;
	logic low_read;
	logic capture;
	logic [7:0] fmt_high;
	logic [7:0] fmt_low;
	logic src_tick;
	logic div_tick;
	logic [7:0] rd_byte;
	logic cfg_change;

	// apb phases; access edge is the one with pready high
	always_comb
	begin
		setup = psel && !penable;
		access = psel && penable && st.pready;
		wr_acc = access && pwrite;
		rd_acc = access && !pwrite;
	end

	// address decode on word index
	always_comb
	begin
		word_idx = paddr[ADDR_W-1:ARF_IDX_SHIFT];
		aligned = (paddr[ARF_IDX_SHIFT-1:0] == '0);
		hit_high = 1'b0;
		hit_low = 1'b0;
		hit_ctrl = 1'b0;
		if (!aligned)
		begin
			hit_high = 1'b0;
		end
		else if (word_idx == (ADDR_W-ARF_IDX_SHIFT)'(ARF_IDX_RESULT_HIGH))
		begin
			hit_high = 1'b1;
		end
		else if (word_idx == (ADDR_W-ARF_IDX_SHIFT)'(ARF_IDX_RESULT_LOW))
		begin
			hit_low = 1'b1;
		end
		else if (word_idx == (ADDR_W-ARF_IDX_SHIFT)'(ARF_IDX_CLOCK_CONTROL))
		begin
			hit_ctrl = 1'b1;
		end
		hit_any = hit_high || hit_low || hit_ctrl;
	end

	// control register image and write fields
	always_comb
	begin
		ctrl_rd = '0;
		ctrl_rd[ARF_PRE_LSB +: ARF_PRE_W] = st.prescale;
		ctrl_rd[ARF_ICS_BIT] = st.clk_sel;
		ctrl_rd[ARF_MODE_LSB +: ARF_MODE_W] = st.mode;
		wr_byte = pwdata[ARF_BYTE_W-1:0];
		wr_pre = wr_byte[ARF_PRE_LSB +: ARF_PRE_W];
		wr_sel = wr_byte[ARF_ICS_BIT];
		wr_mode = arf_mode_e'(wr_byte[ARF_MODE_LSB +: ARF_MODE_W]);
	end

	// read data of the register addressed in the setup cycle
	always_comb
	begin
		rd_byte = ARF_RESULT_RESET;
		if (pwrite)
		begin
			rd_byte = ARF_RESULT_RESET;
		end
		else if (hit_high)
		begin
			rd_byte = st.high;
		end
		else if (hit_low)
		begin
			rd_byte = st.low;
		end
		else if (hit_ctrl)
		begin
			rd_byte = ctrl_rd;
		end
	end

	// divider setup change carried by a control write
	always_comb
	begin
		cfg_change = (wr_pre != st.prescale) || (wr_sel != st.clk_sel);
	end

	// layout of a finished result per justification mode
	always_comb
	begin
		fmt_high = ARF_RESULT_RESET;
		fmt_low = ARF_RESULT_RESET;
		case (st.mode)
			ARF_MODE_TRUNC:
			begin
				fmt_high = ARF_RESULT_RESET;
				fmt_low = conv_result[9:2];
			end
			ARF_MODE_RIGHT:
			begin
				fmt_high = {6'h00, conv_result[9:8]};
				fmt_low = conv_result[7:0];
			end
			ARF_MODE_LEFT:
			begin
				fmt_high = conv_result[9:2];
				fmt_low = {conv_result[1:0], 6'h00};
			end
			ARF_MODE_LEFT_SIGNED:
			begin
				fmt_high = {~conv_result[9], conv_result[8:2]};
				fmt_low = {conv_result[1:0], 6'h00};
			end
			default:
			begin
				fmt_high = ARF_RESULT_RESET;
				fmt_low = ARF_RESULT_RESET;
			end
		endcase
	end

	// read side effects and capture decision
	always_comb
	begin
		high_read = rd_acc && hit_high && (st.mode != ARF_MODE_TRUNC);
		low_read = rd_acc && hit_low;
		// truncated mode has no interlock; outside it a high read this edge wins over a new result
		capture = conv_done && !high_read
			&& ((st.mode == ARF_MODE_TRUNC) || (st.lock == ARF_LOCK_OPEN));
	end

	// conversion clock source: bus clock every cycle, oscillator on its rising edge
	// oscillator must stay below half of pclk to be seen
	always_comb
	begin
		if (st.clk_sel == ARF_ICS_BUS)
			src_tick = 1'b1;
		else
			src_tick = oscillator_clock && !st.osc_q;
	end

	always_comb
	begin
		next_st = st;
		next_st.osc_q = oscillator_clock;
		next_st.restart = 1'b0;
		next_st.pslverr = 1'b0;
		// one wait-free answer: pready in the first access cycle
		next_st.pready = setup;

		if (setup)
		begin
			next_st.prdata = ARF_RDATA_ZERO;
			next_st.prdata[ARF_BYTE_W-1:0] = rd_byte;
			next_st.pslverr = !hit_any;
		end

		if (wr_acc && hit_ctrl)
		begin
			next_st.prescale = wr_pre;
			next_st.clk_sel = wr_sel;
			next_st.mode = wr_mode;
			// any change of divider setup restarts the prescaler
			next_st.restart = cfg_change;
		end

		// one-hot interlock; a stray code reopens it
		case (st.lock)
			ARF_LOCK_OPEN:
			begin
				if (high_read)
					next_st.lock = ARF_LOCK_HELD;
			end
			ARF_LOCK_HELD:
			begin
				if (low_read)
					next_st.lock = ARF_LOCK_OPEN;
			end
			default:
			begin
				next_st.lock = ARF_LOCK_OPEN;
			end
		endcase

		// held lock blocks capture outside truncated mode, so the low byte stays frozen
		if (capture)
		begin
			next_st.high = fmt_high;
			next_st.low = fmt_low;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st.high <= ARF_RESULT_RESET;
			st.low <= ARF_RESULT_RESET;
			st.prescale <= ARF_PRE_RESET;
			st.clk_sel <= ARF_ICS_OSC;
			st.mode <= ARF_MODE_RESET;
			st.lock <= ARF_LOCK_OPEN;
			st.osc_q <= 1'b0;
			st.restart <= 1'b0;
			st.prdata <= ARF_RDATA_ZERO;
			st.pready <= 1'b0;
			st.pslverr <= 1'b0;
		end
		else
		begin
			st <= next_st;
		end
	end

	// conversion clock enable, one pclk wide, held high at divide by one on the bus clock
	arf_prescaler
	#(
		.CNT_W(ARF_DIV_CNT_W)
	)
	u_prescaler
	(
		.pclk(pclk),
		.presetn(presetn),
		.src_tick(src_tick),
		.restart(st.restart),
		.div_code(st.prescale),
		.conv_tick(div_tick)
	);

	assign prdata = st.prdata;
	assign pready = st.pready;
	assign pslverr = st.pslverr;
	assign conv_clk_en = div_tick;
	assign result_high_byte = st.high;
	assign result_low_byte = st.low;

endmodule

// >>> verif/arf_core_model.sv
// converter core model: result pulses and free oscillator clock
`timescale 1ns/1ns
module arf_core_model
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic go,
	input wire logic [9:0] val,
	output logic conv_done,
	output logic [9:0] conv_result,
	output logic oscillator_clock
);
	logic [2:0] ph;
	assign oscillator_clock = ph[2];
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ph <= 3'h0;
			conv_done <= 1'h0;
			conv_result <= 10'h0;
		end
		else
		begin
			ph <= ph + 3'h1;
			conv_done <= go;
			conv_result <= go ? val : ~conv_result;
		end
	end
endmodule

// >>> verif/arf_top_asserts.sv
// assertion checker bound to arf_top
`timescale 1ns/1ns
module arf_chk
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [9:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic conv_done,
	input wire logic [9:0] conv_result,
	input wire logic conv_clk_en,
	input wire logic [7:0] result_high_byte,
	input wire logic [7:0] result_low_byte
);
	logic [7:0] ctl;
	logic lk;
	logic [5:0] since;
	logic [4:0] gap;
	wire acc = psel && penable && pready;
	wire rh = acc && !pwrite && paddr == 10'h0F4;
	wire rl = acc && !pwrite && paddr == 10'h0F8;
	wire wc = acc && pwrite && paddr == 10'h0FC;
	wire on = ctl[3:2] != 2'h0;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctl <= 8'h04;
			lk <= 1'h0;
			since <= 6'h0;
			gap <= 5'h0;
		end
		else
		begin
			if (wc)
				ctl <= pwdata[7:0] & 8'hFC;
			if (rl)
				lk <= 1'h0;
			else if (rh && on)
				lk <= 1'h1;
			since <= wc ? 6'h0 : since + 6'(since != 6'h3F);
			gap <= conv_clk_en ? 5'h0 : gap + 5'(gap != 5'h1F);
		end
	end
	default clocking dc @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_SIGNED:
	assert property (conv_done && ctl[3:2] == 2'h3 && !lk && !rh && !rl |=>
		result_high_byte == {~$past(conv_result[9]), $past(conv_result[8:2])} &&
		result_low_byte == {$past(conv_result[1:0]), 6'h00})
		else $error("signed layout wrong");
	AST_FREEZE:
	assert property (lk && on && !rl |=> $stable(result_low_byte) && $stable(result_high_byte))
		else $error("result changed while held");
	AST_LOW_EDGE:
	assert property (rl && lk && on |=> $stable(result_low_byte))
		else $error("result taken on low read");
	AST_CTRL_READ:
	assert property (acc && !pwrite && paddr == 10'h0FC |-> prdata == {24'h0, ctl})
		else $error("control readback wrong");
	AST_DIV1:
	assert property (ctl[7:4] == 4'h1 && since > 6'h3 |-> conv_clk_en)
		else $error("no pulse at divide by one");
	AST_PERIOD:
	assert property (conv_clk_en && ctl[4] && since == 6'h3F |->
		gap == (ctl[7] ? 5'hF : 5'((5'h1 << ctl[6:5]) - 5'h1)))
		else $error("divide period wrong");
	AST_OSC_PULSE:
	assert property (conv_clk_en && !ctl[4] && since > 6'h3 |=> !conv_clk_en)
		else $error("pulse longer than one cycle");
	AST_UNMAPPED:
	assert property (psel && !penable && !(paddr inside {10'h0F4, 10'h0F8, 10'h0FC}) |=>
		pslverr && prdata == 32'h0)
		else $error("unmapped access not flagged");
endmodule
bind arf_top arf_chk i_chk
(
	.pclk(pclk),
	.presetn(presetn),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.paddr(paddr),
	.pwdata(pwdata),
	.prdata(prdata),
	.pready(pready),
	.pslverr(pslverr),
	.conv_done(conv_done),
	.conv_result(conv_result),
	.conv_clk_en(conv_clk_en),
	.result_high_byte(result_high_byte),
	.result_low_byte(result_low_byte)
);

// >>> verif/tb_adc_result_format_and_clock.sv
// self-checking bench for arf_top with converter core model
`timescale 1ns/1ns
module tb_adc_result_format_and_clock;
	logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, go = 1'h0;
	logic [9:0] paddr = 10'h0, val = 10'h0, conv_result, r1, r2;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic pready, pslverr, conv_done, oscillator_clock, conv_clk_en, e;
	logic [7:0] result_high_byte, result_low_byte;
	logic [15:0] x1, x2;
	int fail_count = 0, check_count = 0, seed = 34, n;
	always #5 pclk = ~pclk;
	arf_top i_dut
	(
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.oscillator_clock(oscillator_clock),
		.conv_done(conv_done),
		.conv_result(conv_result),
		.conv_clk_en(conv_clk_en),
		.result_high_byte(result_high_byte),
		.result_low_byte(result_low_byte)
	);
	arf_core_model i_core
	(
		.pclk(pclk),
		.presetn(presetn),
		.go(go),
		.val(val),
		.conv_done(conv_done),
		.conv_result(conv_result),
		.oscillator_clock(oscillator_clock)
	);
	function automatic logic [15:0] fx(logic [1:0] m, logic [9:0] r);
		case (m)
			2'h0: fx = {8'h00, r[9:2]};
			2'h1: fx = {6'h00, r};
			2'h2: fx = {r, 6'h00};
			default: fx = {~r[9], r[8:0], 6'h00};
		endcase
	endfunction
	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		check_count++;
		if (s !== x)
		begin
			fail_count++;
			$display("CHECK FAILED %0t: saw %h want %h", $time, s, x);
		end
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'h1 && n < 9);
		if (pready !== 1'h1)
		begin
			fail_count++;
			close_out;
		end
		else
		begin
			q = prdata;
			e = pslverr;
			psel <= 1'h0;
			penable <= 1'h0;
			@(posedge pclk);
		end
	endtask
	task automatic conv(input logic [9:0] r);
		go <= 1'h1;
		val <= r;
		@(posedge pclk);
		go <= 1'h0;
		repeat (3) @(posedge pclk);
	endtask
	initial
	begin
		repeat (10) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		apb(1'h0, 10'h0FC, 32'h0);
		chk(q, 32'h4);
		apb(1'h0, 10'h0F4, 32'h0);
		apb(1'h1, 10'h0F4, 32'hFF);
		apb(1'h0, 10'h0F4, 32'h0);
		chk(q, 32'h0);
		apb(1'h0, 10'h0F8, 32'h0);
		chk(q, 32'h0);
		apb(1'h0, 10'h3F0, 32'h0);
		chk({31'h0, e}, 32'h1);
		apb(1'h0, 10'h0F5, 32'h0);
		chk({31'h0, e}, 32'h1);
		for (int m = 0; m < 4; m++)
		begin
			apb(1'h1, 10'h0FC, {28'h1, 2'(m), 2'h0});
			for (int k = 0; k < 6; k++)
			begin
				r1 = k ? 10'($random(seed)) : 10'h3FF;
				r2 = k ? 10'($random(seed)) : 10'h200;
				x1 = fx(2'(m), r1);
				x2 = fx(2'(m), r2);
				conv(r1);
				apb(1'h0, 10'h0F4, 32'h0);
				chk(q, {24'h0, x1[15:8]});
				conv(r2);
				apb(1'h0, 10'h0F8, 32'h0);
				chk(q, {24'h0, m ? x1[7:0] : x2[7:0]});
			end
		end
		r2 = 10'($random(seed));
		fork
			apb(1'h0, 10'h0F4, 32'h0);
			conv(r2);
		join
		chk(q, {24'h0, x1[15:8]});
		fork
			apb(1'h0, 10'h0F8, 32'h0);
			conv(r2);
		join
		chk(q, {24'h0, x1[7:0]});
		apb(1'h0, 10'h0F4, 32'h0);
		chk(q, {24'h0, x1[15:8]});
		apb(1'h0, 10'h0F8, 32'h0);
		chk(q, {24'h0, x1[7:0]});
		for (int i = 0; i < 10; i++)
		begin
			apb(1'h1, 10'h0FC, {24'h0, 3'(i % 8), 1'(i < 8), 4'h4});
			repeat (40) @(posedge pclk);
			n = 0;
			repeat (64)
			begin
				@(posedge pclk);
				n += conv_clk_en;
			end
			chk(32'(n), 32'(64 / ((i < 8 ? 1 : 8) << (i > 3 && i < 8 ? 4 : i % 8))));
		end
		presetn <= 1'h0;
		repeat (3) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		apb(1'h0, 10'h0FC, 32'h0);
		chk(q, 32'h4);
		apb(1'h0, 10'h0F4, 32'h0);
		chk(q, 32'h0);
		apb(1'h0, 10'h0F8, 32'h0);
		chk(q, 32'h0);
		apb(1'h1, 10'h0FC, 32'h8C);
		apb(1'h0, 10'h0FC, 32'h0);
		chk(q, 32'h8C);
		close_out;
	end
endmodule
